//--- hdl/wcb_coalescing_line_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Loads of coalescing memory go to memory, never read buffered data.
// - Two dedicated entries of 64 bytes, used only for coalescing stores.
// - Every byte of a line has a valid flag set by a store.
// - A line with every byte valid is full and evicted unprompted.
// - Any flush trigger evicts both entries.
// - Fence or release-ordered operations trigger a whole-buffer flush.
// - A cache-line flush hitting a buffered line triggers a flush.
// - A buffer-flush instruction always triggers a flush.
// - Uncacheable loads, stores and fetches never trigger a flush.
// - Well-behaved streams are evicted in allocation order.
// - Other streams may see the two entries evicted in any order.
// - Stores after a partial flush coalesce into a fresh entry.
// - A full line leaves as one 64-byte burst of 8-byte beats.
// - A partial line leaves as up to eight byte-enabled 8-byte transfers.
// - While flushing, eviction wins over all other bus requests.
module wcb_coalescing_line_buffer
  import wcb_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       op_valid_i,
  input  wire wcb_op_t                    op_code_i,
  input  wire wcb_mtype_t                 op_mtype_i,
  input  wire logic [WCB_PA_W-1:0]        op_addr_i,
  input  wire logic [WCB_CHUNK_W-1:0]     op_data_i,
  input  wire logic [WCB_CHUNK_BYTES-1:0] op_be_i,
  output logic                            op_ready_o,
  input  wire logic                       other_req_i,
  output logic                            other_gnt_o,
  input  wire logic                       bus_gnt_i,
  output logic                            bus_req_o,
  output logic                            bus_own_o,
  output logic [WCB_PA_W-1:0]             bus_addr_o,
  output logic [WCB_CHUNK_W-1:0]          bus_data_o,
  output logic [WCB_CHUNK_BYTES-1:0]      bus_be_o,
  output logic                            bus_burst_o,
  output logic                            bus_first_o,
  output logic                            bus_last_o,
  output logic                            bus_flush_o,
  output logic                            wcb_empty_o
);

  wcb_ctl_t q;
  wcb_ctl_t d;

  logic [WCB_ENTRIES-1:0]     ent_valid;
  logic [WCB_ENTRIES-1:0]     ent_full;
  logic [WCB_ENTRIES-1:0]     ent_hit;
  logic [WCB_ENTRIES-1:0]     ent_alloc;
  logic [WCB_ENTRIES-1:0]     ent_wr;
  logic [WCB_ENTRIES-1:0]     ent_clr;
  logic [WCB_TAG_W-1:0]       ent_tag  [WCB_ENTRIES];
  logic [WCB_CHUNK_W-1:0]     ent_data [WCB_ENTRIES];
  logic [WCB_CHUNK_BYTES-1:0] ent_be   [WCB_ENTRIES];

  logic [WCB_TAG_W-1:0]       op_tag;
  logic [WCB_CIDX_W-1:0]      op_chunk;
  logic [WCB_CIDX_W-1:0]      rd_chunk;
  logic                       is_store;
  logic                       store_hit;
  logic                       hit_idx;
  logic                       any_free;
  logic                       free_idx;
  logic                       blocked;
  logic                       st_go;
  logic                       trig;
  logic                       wcb_sel;
  logic                       beat_ok;
  logic                       finish;
  logic [WCB_CHUNK_W-1:0]     sel_data;
  logic [WCB_CHUNK_BYTES-1:0] sel_be;

  // ----------------------------------------------------------------
  // Line entries
  // ----------------------------------------------------------------
  for (genvar e = 0; e < WCB_ENTRIES; e++) begin : g_ent
    // Private to coalescing stores; no other store path writes here
    wcb_line_entry u_entry (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .alloc_i     (ent_alloc[e]),
      .alloc_tag_i (op_tag),
      .wr_i        (ent_wr[e]),
      .wr_chunk_i  (op_chunk),
      .wr_data_i   (op_data_i),
      .wr_be_i     (op_be_i),
      .clr_i       (ent_clr[e]),
      .rd_chunk_i  (rd_chunk),
      .valid_o     (ent_valid[e]),
      .tag_o       (ent_tag[e]),
      .full_o      (ent_full[e]),
      .rd_data_o   (ent_data[e]),
      .rd_be_o     (ent_be[e])
    );
    assign ent_hit[e] = ent_valid[e] & (ent_tag[e] == op_tag);
  end

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  assign op_tag    = op_addr_i[WCB_PA_W-1:WCB_OFF_W];
  assign op_chunk  = op_addr_i[WCB_OFF_W-1:WCB_BOFF_W];
  assign store_hit = |ent_hit;
  assign hit_idx   = ent_hit[1];
  assign any_free  = ~(&ent_valid);
  assign free_idx  = ent_valid[0];

  // Only coalescing-type stores enter; loads and fetches never read lines
  assign is_store = op_valid_i & (op_code_i == WCB_STORE_OP)
                  & (op_mtype_i == WCB_WRITE_COALESCING_TYPE);

  // Stall during a flush and on lines already queued or draining, so a
  // store can never land in a line after its bytes were sent out
  always_comb begin
    blocked = q.flush;
    if (store_hit) begin
      if (q.pend[hit_idx] | ((q.state != WCB_S_IDLE) & (q.ev == hit_idx))) begin
        blocked = 1'b1;
      end
    end else if (!any_free) begin
      blocked = 1'b1;
    end
  end

  assign op_ready_o = ~(is_store & blocked);
  assign st_go      = is_store & ~blocked;

  for (genvar e = 0; e < WCB_ENTRIES; e++) begin : g_wr
    assign ent_wr[e]    = st_go & (store_hit ? (hit_idx == e) : (free_idx == e));
    assign ent_alloc[e] = st_go & ~store_hit & (free_idx == e);
  end

  // Flush triggers; memory type is ignored so uncacheable loads, stores and
  // fetches, hit or not, leave the buffer alone
  always_comb begin
    trig = 1'b0;
    if (op_valid_i) begin
      unique case (op_code_i)
        WCB_MEMORY_FENCE_OP:     trig = 1'b1;
        WCB_RELEASE_ORDERED_OP:  trig = 1'b1;
        WCB_CACHE_LINE_FLUSH_OP: trig = store_hit;
        WCB_BUFFER_FLUSH_OP:     trig = 1'b1;
        default:                 trig = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus arbitration
  // ----------------------------------------------------------------
  // Outside a flush other traffic goes first; eviction then waits
  assign wcb_sel     = (q.state == WCB_S_SEND) & (q.flush | ~other_req_i);
  assign beat_ok     = wcb_sel & bus_gnt_i;
  assign bus_req_o   = (q.state == WCB_S_SEND) | other_req_i;
  assign other_gnt_o = bus_gnt_i & other_req_i & ~wcb_sel;
  assign bus_own_o   = wcb_sel;

  assign rd_chunk = (q.state == WCB_S_SEND) ? (q.chunk + WCB_CIDX_STEP) : q.chunk;
  assign sel_data = ent_data[q.ev];
  assign sel_be   = ent_be[q.ev];

  // ----------------------------------------------------------------
  // Eviction sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    finish = 1'b0;
    ent_clr = '0;

    unique case (q.state)
      WCB_S_IDLE: begin
        if (|q.pend) begin
          // Oldest first; for out-of-order fill the pick is arbitrary
          d.ev    = (&q.pend) ? q.old : q.pend[1];
          d.chunk = WCB_CIDX_FIRST;
          d.burst = ent_full[d.ev];
          d.state = WCB_S_LOAD;
        end
      end
      WCB_S_LOAD: begin
        if (q.burst | (|sel_be)) begin
          d.addr  = {ent_tag[q.ev], q.chunk, WCB_BOFF_ZERO};
          d.data  = sel_data;
          d.be    = q.burst ? WCB_BE_ALL : sel_be;
          d.first = q.burst ? (q.chunk == WCB_CIDX_FIRST) : 1'b1;
          d.last  = q.burst ? (q.chunk == WCB_CIDX_LAST) : 1'b1;
          d.state = WCB_S_SEND;
        end else if (q.chunk == WCB_CIDX_LAST) begin
          finish = 1'b1;
        end else begin
          // Empty chunks are skipped and cost no bus transfer
          d.chunk = q.chunk + WCB_CIDX_STEP;
        end
      end
      WCB_S_SEND: begin
        if (beat_ok) begin
          if (q.chunk == WCB_CIDX_LAST) begin
            finish = 1'b1;
          end else if (q.burst) begin
            // Next beat loaded at once so the burst has no gaps
            d.chunk = q.chunk + WCB_CIDX_STEP;
            d.addr  = {ent_tag[q.ev], d.chunk, WCB_BOFF_ZERO};
            d.data  = sel_data;
            d.be    = WCB_BE_ALL;
            d.first = 1'b0;
            d.last  = (d.chunk == WCB_CIDX_LAST);
          end else begin
            d.chunk = q.chunk + WCB_CIDX_STEP;
            d.state = WCB_S_LOAD;
          end
        end
      end
    endcase

    if (finish) begin
      ent_clr[q.ev] = 1'b1;
      d.pend[q.ev]  = 1'b0;
      d.state       = WCB_S_IDLE;
    end

    // ------------------------------------------------------------
    // Queueing of entries for eviction
    // ------------------------------------------------------------
    if (trig) begin
      d.pend = d.pend | (ent_valid & ~ent_clr);
    end
    d.pend = d.pend | (ent_full & ~ent_clr);
    if (is_store & ~store_hit & ~any_free & ~q.flush & ~ent_clr[q.old]) begin
      d.pend[q.old] = 1'b1;
    end

    // A new trigger wins over the end of the running flush
    d.flush = trig | (q.flush & ((|d.pend) | (d.state != WCB_S_IDLE)));

    // ------------------------------------------------------------
    // Allocation age
    // ------------------------------------------------------------
    for (int unsigned e = 0; e < WCB_ENTRIES; e++) begin
      if (ent_alloc[e] & ~ent_valid[1 - e]) begin
        d.old = e[0];
      end
    end
    if (finish) begin
      d.old = ~q.ev;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= WCB_CTL_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_addr_o  = q.addr;
  assign bus_data_o  = q.data;
  assign bus_be_o    = q.be;
  assign bus_burst_o = q.burst;
  assign bus_first_o = q.first;
  assign bus_last_o  = q.last;
  assign bus_flush_o = q.flush;
  assign wcb_empty_o = ~(|ent_valid) & (q.state == WCB_S_IDLE);

endmodule

`default_nettype wire

//--- shared/wcb_pkg.sv
`default_nettype none

package wcb_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned WCB_PA_W        = 44;
  localparam int unsigned WCB_ENTRIES     = 2;
  localparam int unsigned WCB_LINE_BYTES  = 64;
  localparam int unsigned WCB_CHUNK_BYTES = 8;
  localparam int unsigned WCB_CHUNKS      = WCB_LINE_BYTES / WCB_CHUNK_BYTES;
  localparam int unsigned WCB_OFF_W       = 6;
  localparam int unsigned WCB_BOFF_W      = 3;
  localparam int unsigned WCB_CIDX_W      = WCB_OFF_W - WCB_BOFF_W;
  localparam int unsigned WCB_TAG_W       = WCB_PA_W - WCB_OFF_W;
  localparam int unsigned WCB_CHUNK_W     = WCB_CHUNK_BYTES * 8;
  localparam int unsigned WCB_LINE_W      = WCB_LINE_BYTES * 8;

  localparam logic [WCB_CIDX_W-1:0]      WCB_CIDX_FIRST = 3'h0;
  localparam logic [WCB_CIDX_W-1:0]      WCB_CIDX_LAST  = 3'h7;
  localparam logic [WCB_CIDX_W-1:0]      WCB_CIDX_STEP  = 3'h1;
  localparam logic [WCB_BOFF_W-1:0]      WCB_BOFF_ZERO  = 3'h0;
  localparam logic [WCB_CHUNK_BYTES-1:0] WCB_BE_ALL     = 8'hff;

  // ----------------------------------------------------------------
  // Operation codes and memory types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WCB_STORE_OP             = 3'h0,
    WCB_LOAD_OP              = 3'h1,
    WCB_IFETCH_OP            = 3'h2,
    WCB_MEMORY_FENCE_OP      = 3'h3,
    WCB_RELEASE_ORDERED_OP   = 3'h4,
    WCB_CACHE_LINE_FLUSH_OP  = 3'h5,
    WCB_BUFFER_FLUSH_OP      = 3'h6
  } wcb_op_t;

  typedef enum logic [1:0] {
    WCB_WRITE_COALESCING_TYPE = 2'h0,
    WCB_UNCACHEABLE_TYPE      = 2'h1,
    WCB_OTHER_TYPE            = 2'h2
  } wcb_mtype_t;

  // ----------------------------------------------------------------
  // Eviction sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WCB_S_IDLE = 3'h1,
    WCB_S_LOAD = 3'h2,
    WCB_S_SEND = 3'h4
  } wcb_state_t;

  typedef struct packed {
    logic                   valid;
    logic [WCB_TAG_W-1:0]   tag;
    logic [WCB_LINE_BYTES-1:0] bv;
    logic [WCB_LINE_W-1:0]  data;
  } wcb_entry_t;

  typedef struct packed {
    wcb_state_t                 state;
    logic [WCB_ENTRIES-1:0]     pend;
    logic                       flush;
    logic                       old;
    logic                       ev;
    logic [WCB_CIDX_W-1:0]      chunk;
    logic                       burst;
    logic [WCB_PA_W-1:0]        addr;
    logic [WCB_CHUNK_W-1:0]     data;
    logic [WCB_CHUNK_BYTES-1:0] be;
    logic                       first;
    logic                       last;
  } wcb_ctl_t;

  localparam wcb_entry_t WCB_ENTRY_RST = '0;
  localparam wcb_ctl_t   WCB_CTL_RST   = '{state: WCB_S_IDLE, default: '0};

endpackage

`default_nettype wire

//--- hdl/wcb_line_entry.sv
`timescale 1ns/1ps
`default_nettype none

module wcb_line_entry
  import wcb_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       alloc_i,
  input  wire logic [WCB_TAG_W-1:0]       alloc_tag_i,
  input  wire logic                       wr_i,
  input  wire logic [WCB_CIDX_W-1:0]      wr_chunk_i,
  input  wire logic [WCB_CHUNK_W-1:0]     wr_data_i,
  input  wire logic [WCB_CHUNK_BYTES-1:0] wr_be_i,
  input  wire logic                       clr_i,
  input  wire logic [WCB_CIDX_W-1:0]      rd_chunk_i,
  output logic                            valid_o,
  output logic [WCB_TAG_W-1:0]            tag_o,
  output logic                            full_o,
  output logic [WCB_CHUNK_W-1:0]          rd_data_o,
  output logic [WCB_CHUNK_BYTES-1:0]      rd_be_o
);

  wcb_entry_t q;
  wcb_entry_t d;

  // ----------------------------------------------------------------
  // Line storage with one valid flag per byte
  // ----------------------------------------------------------------
  always_comb begin
    int unsigned base;
    base = 0;
    d = q;
    if (clr_i) begin
      d.valid = 1'b0;
      d.bv    = '0;
    end
    if (alloc_i) begin
      // A fresh entry starts with no bytes valid
      d.valid = 1'b1;
      d.tag   = alloc_tag_i;
      d.bv    = '0;
    end
    if (wr_i) begin
      base = int'(wr_chunk_i) * WCB_CHUNK_BYTES;
      for (int unsigned i = 0; i < WCB_CHUNK_BYTES; i++) begin
        if (wr_be_i[i]) begin
          d.bv[base + i]               = 1'b1;
          d.data[(base + i) * 8 +: 8]  = wr_data_i[i * 8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= WCB_ENTRY_RST;
    end else begin
      q <= d;
    end
  end

  assign valid_o   = q.valid;
  assign tag_o     = q.tag;
  assign full_o    = q.valid & (&q.bv);
  assign rd_data_o = q.data[int'(rd_chunk_i) * WCB_CHUNK_W +: WCB_CHUNK_W];
  assign rd_be_o   = q.bv[int'(rd_chunk_i) * WCB_CHUNK_BYTES +: WCB_CHUNK_BYTES];

endmodule

`default_nettype wire

//--- test/wcb_coalescing_line_buffer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module wcb_checker
  import wcb_pkg::*;
(
  input wire logic                       mclk_i,
  input wire logic                       rst_n_i,
  input wire logic                       op_valid_i,
  input wire wcb_op_t                    op_code_i,
  input wire wcb_mtype_t                 op_mtype_i,
  input wire logic                       other_req_i,
  input wire logic                       bus_gnt_i,
  input wire logic                       bus_own_o,
  input wire logic [WCB_PA_W-1:0]        bus_addr_o,
  input wire logic [WCB_CHUNK_BYTES-1:0] bus_be_o,
  input wire logic                       bus_burst_o,
  input wire logic                       bus_first_o,
  input wire logic                       bus_last_o,
  input wire logic                       bus_flush_o,
  input wire logic                       wcb_empty_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // Beat shape and ordering
  // ----------------------------------------
  property p_hold;
    bus_own_o && !bus_gnt_i |=> $stable(bus_addr_o) && $stable(bus_be_o);
  endproperty
  a_hold: assert property (p_hold) else $error("beat moved before grant");
  property p_prio;
    bus_flush_o && other_req_i && bus_own_o && !bus_gnt_i |=> bus_own_o;
  endproperty
  a_prio: assert property (p_prio) else $error("flush beat lost the bus");
  property p_step;
    bus_own_o && bus_gnt_i && bus_burst_o && !bus_last_o
      |=> bus_burst_o && !bus_first_o && bus_addr_o == $past(bus_addr_o) + 44'h8;
  endproperty
  a_step: assert property (p_step) else $error("burst beat out of order");
  property p_full;
    bus_own_o && bus_burst_o |-> bus_be_o == WCB_BE_ALL
      && bus_first_o == (bus_addr_o[5:3] == 3'h0) && bus_last_o == (bus_addr_o[5:3] == 3'h7);
  endproperty
  a_full: assert property (p_full) else $error("bad burst framing");
  property p_part;
    bus_own_o && !bus_burst_o |-> bus_first_o && bus_last_o && bus_be_o != 8'h00;
  endproperty
  a_part: assert property (p_part) else $error("bad partial transfer");
  // ----------------------------------------
  // Flush triggers
  // ----------------------------------------
  property p_fence;
    op_valid_i && op_code_i inside {WCB_MEMORY_FENCE_OP, WCB_RELEASE_ORDERED_OP} |=> bus_flush_o;
  endproperty
  a_fence: assert property (p_fence) else $error("fence did not flush");
  property p_fwb;
    op_valid_i && op_code_i == WCB_BUFFER_FLUSH_OP |=> bus_flush_o;
  endproperty
  a_fwb: assert property (p_fwb) else $error("buffer flush ignored");
  property p_unc;
    !bus_flush_o && op_valid_i && op_mtype_i == WCB_UNCACHEABLE_TYPE
      && op_code_i inside {WCB_STORE_OP, WCB_LOAD_OP, WCB_IFETCH_OP} |=> !bus_flush_o;
  endproperty
  a_unc: assert property (p_unc) else $error("uncacheable access flushed");
  property p_drain;
    $rose(bus_flush_o) |-> ##[1:1000] !bus_flush_o;
  endproperty
  a_drain: assert property (p_drain) else $error("flush never ended");
  property p_empty;
    $fell(bus_flush_o) |-> ##[0:1] wcb_empty_o;
  endproperty
  a_empty: assert property (p_empty) else $error("entry left after flush");
  c_burst: cover property (bus_own_o && bus_gnt_i && bus_burst_o && bus_last_o);
  c_part: cover property (bus_own_o && bus_gnt_i && !bus_burst_o);
  c_flush: cover property ($fell(bus_flush_o));
endmodule
bind wcb_coalescing_line_buffer wcb_checker u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .op_mtype_i(op_mtype_i), .other_req_i(other_req_i), .bus_gnt_i(bus_gnt_i),
  .bus_own_o(bus_own_o), .bus_addr_o(bus_addr_o), .bus_be_o(bus_be_o),
  .bus_burst_o(bus_burst_o), .bus_first_o(bus_first_o), .bus_last_o(bus_last_o),
  .bus_flush_o(bus_flush_o), .wcb_empty_o(wcb_empty_o)
);
`default_nettype wire

//--- test/wcb_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module wcb_bus_model (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic bus_req_i,
  input  wire logic slow_i,
  output var  logic bus_gnt_o
);
  logic [7:0] lfsr_q = 8'h5a;
  initial bus_gnt_o = 1'b0;
  // Grants only what is asked; slow mode stalls at random to stretch beats
  always @(negedge mclk_i) begin
    #1;
    lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    bus_gnt_o = rst_n_i && bus_req_i && (!slow_i || lfsr_q[0]);
  end
endmodule
`default_nettype wire

//--- test/wcb_coalescing_line_buffer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module wcb_coalescing_line_buffer_tb_top;
  import wcb_pkg::*;
  localparam logic [WCB_PA_W-1:0] LA = 44'h000_0004_0000;
  localparam wcb_mtype_t MT_CO = WCB_WRITE_COALESCING_TYPE;
  localparam wcb_mtype_t MT_UN = WCB_UNCACHEABLE_TYPE;
  logic                       mclk_i = 1'b0;
  logic                       rst_n_i = 1'b0;
  logic                       op_valid_i = 1'b0;
  wcb_op_t                    op_code_i = WCB_LOAD_OP;
  wcb_mtype_t                 op_mtype_i = WCB_OTHER_TYPE;
  logic [WCB_PA_W-1:0]        op_addr_i = '0;
  logic [WCB_CHUNK_W-1:0]     op_data_i = '0;
  logic [WCB_CHUNK_BYTES-1:0] op_be_i = '0;
  logic                       other_req_i = 1'b0;
  logic                       slow = 1'b0;
  logic                       bus_gnt_i, op_ready_o, other_gnt_o, bus_req_o, bus_own_o;
  logic                       bus_burst_o, bus_first_o, bus_last_o, bus_flush_o, wcb_empty_o;
  logic [WCB_PA_W-1:0]        bus_addr_o;
  logic [WCB_CHUNK_W-1:0]     bus_data_o;
  logic [WCB_CHUNK_BYTES-1:0] bus_be_o;
  logic [118:0]               beat, exp_q [$];
  logic [37:0]                m_tag [2];
  logic [63:0]                m_bv [2] = '{default: '0};
  logic [511:0]               m_dat [2] = '{default: '0};
  int                         m_ord [$];
  logic [15:0]                seed = 16'h003d;
  int                         num_errors = 0;
  int                         samples_checked = 0;
  wcb_op_t trig [4] = '{WCB_MEMORY_FENCE_OP, WCB_RELEASE_ORDERED_OP, WCB_BUFFER_FLUSH_OP,
                        WCB_CACHE_LINE_FLUSH_OP};
  wcb_op_t quiet [5] = '{WCB_STORE_OP, WCB_LOAD_OP, WCB_IFETCH_OP, WCB_LOAD_OP,
                         WCB_CACHE_LINE_FLUSH_OP};

  wcb_coalescing_line_buffer DUT (.*);
  wcb_bus_model u_bus (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_o),
                       .slow_i(slow), .bus_gnt_o(bus_gnt_i));

  always #2.5 mclk_i = ~mclk_i;
  // ----------------------------------------
  // Stimulus helpers and line model
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [7:0] rbe();
    return 8'(rnd()) | 8'h01;
  endfunction
  always @(negedge mclk_i) other_req_i <= rnd() > 16'h8000;
  task automatic check(input logic [118:0] seen, input logic [118:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic emit(input int e);
    logic [43:0] a;
    for (int c = 0; c < 8; c++) begin
      a = {m_tag[e], 3'(c), 3'h0};
      if (&m_bv[e])
        exp_q.push_back({1'b1, c == 0, c == 7, 8'hff, a, m_dat[e][64*c+:64]});
      else if (m_bv[e][8*c+:8] != 8'h00)
        exp_q.push_back({3'h3, m_bv[e][8*c+:8], a, m_dat[e][64*c+:64]});
    end
    m_bv[e] = '0;
    m_dat[e] = '0;
    m_ord = m_ord.find(x) with (x != e);
  endtask
  function automatic int find_line(input logic [43:0] a);
    int e;
    e = -1;
    foreach (m_ord[i]) if (m_tag[m_ord[i]] == a[43:6]) e = m_ord[i];
    return e;
  endfunction
  task automatic mstore(input logic [43:0] a, input logic [63:0] d, input logic [7:0] be);
    int e;
    e = find_line(a);
    if (e < 0) begin
      if (m_ord.size() == 2) emit(m_ord[0]);
      e = (m_ord.size() == 1 && m_ord[0] == 0) ? 1 : 0;
      m_tag[e] = a[43:6];
      m_ord.push_back(e);
    end
    for (int b = 0; b < 8; b++)
      if (be[b]) begin
        m_bv[e][8*a[5:3]+b] = 1'b1;
        m_dat[e][64*a[5:3]+8*b+:8] = d[8*b+:8];
      end
    if (&m_bv[e]) emit(e);
  endtask
  task automatic op(input wcb_op_t c, input wcb_mtype_t t, input logic [43:0] a,
                    input logic [63:0] d = '0, input logic [7:0] be = '0);
    int n;
    logic r;
    n = 0;
    op_valid_i = 1'b1;
    op_code_i = c;
    op_mtype_i = t;
    op_addr_i = a;
    op_data_i = d;
    op_be_i = be;
    if (c == WCB_STORE_OP && t == MT_CO)
      mstore(a, d, be);
    else if (c inside {WCB_MEMORY_FENCE_OP, WCB_RELEASE_ORDERED_OP, WCB_BUFFER_FLUSH_OP}
             || (c == WCB_CACHE_LINE_FLUSH_OP && find_line(a) >= 0))
      while (m_ord.size() > 0) emit(m_ord[0]);
    do begin
      #2;
      r = op_ready_o;
      @(negedge mclk_i);
      n++;
    end while (r !== 1'b1 && n < 4000);
    if (r !== 1'b1) num_errors++;
  endtask
  task automatic drain();
    int n;
    n = 0;
    op_valid_i = 1'b0;
    while (!(wcb_empty_o === 1'b1 && exp_q.size() == 0) && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    check(exp_q.size(), 0);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Beats are compared in order, half a ns before the sampling edge
  always @(negedge mclk_i) begin
    #2;
    // Our beat and the other requester are never granted together
    if (rst_n_i) check({bus_own_o & other_gnt_o, bus_own_o & ~bus_req_o}, 2'b00);
    if (rst_n_i && bus_own_o === 1'b1 && bus_gnt_i === 1'b1) begin
      beat = {bus_burst_o, bus_first_o, bus_last_o, bus_be_o, bus_addr_o, bus_data_o};
      for (int b = 0; b < 8; b++)
        if (bus_be_o[b] !== 1'b1) beat[8*b+:8] = 8'h00;
      if (exp_q.size() == 0) check(beat, ~beat);
      else check(beat, exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge mclk_i);
    check(wcb_empty_o, 1'b1);
    check(op_ready_o, 1'b1);
    rst_n_i = 1'b1;
    @(negedge mclk_i);
    for (int i = 0; i < 16; i++)
      op(WCB_STORE_OP, MT_CO, LA + 44'h8 * i, {rnd(), rnd(), rnd(), rnd()}, 8'hff);
    drain();
    foreach (trig[i]) begin
      slow = i[0];
      op(WCB_STORE_OP, MT_CO, LA + 44'h8 * i, {rnd(), rnd(), rnd(), rnd()}, rbe());
      op(WCB_STORE_OP, MT_CO, LA + 44'h48 + 44'h8 * i, {rnd(), rnd(), rnd(), rnd()}, rbe());
      foreach (quiet[k]) op(quiet[k], k < 3 ? MT_UN : MT_CO, LA + (k == 4 ? 44'h80 : 44'h0));
      op_valid_i = 1'b0;
      repeat (20) @(negedge mclk_i);
      check(wcb_empty_o, 1'b0);
      op(trig[i], MT_CO, LA + 44'h40);
      drain();
    end
    slow = 1'b1;
    for (int i = 0; i < 3; i++)
      op(WCB_STORE_OP, MT_CO, LA + 44'h40 * i, {rnd(), rnd(), rnd(), rnd()}, rbe());
    op(WCB_MEMORY_FENCE_OP, MT_CO, LA);
    op(WCB_STORE_OP, MT_CO, LA + 44'h100, {rnd(), rnd(), rnd(), rnd()}, rbe());
    op(WCB_BUFFER_FLUSH_OP, MT_UN, LA);
    drain();
    tally_and_finish();
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
